// >>> rtl/rss_spi_slave.sv
/*
  rss_spi_slave: serial slave port and start-up control of a single-axis
  rate sensor. Input bits are shifted on the master's serial clock; the
  response, register file and start-up sequencing run on sys_clk.
  Assumes the sensing core supplies rate, temperature and fault events
  on sys_clk, and that the master keeps chip select high between frames
  for several sys_clk cycles.
*/
// Functional notes
// - load config, valid data after 620 ms
// - 60 Hz default, 01b selects 10 Hz
// - serial port ignored until 20 ms
// - invalid filter: use 00b, flag common fail
// - valid data 750 ms (10 Hz), 620 ms
// - start-up sets flags; master reads to clear
// - clean start-up reads summary 0041h
// - accel register read returns failure status
// - slave only, separate in and out lines
// - response lags request by one frame
// - 32-bit frames, msb first
// - chip select frames; mode 0 edges
// - op, status, data, checksum bit fields
// - op msb writes, low five address; echoed
// - checksum over bits 31..8 in low byte
// - filter field 10b selects 60 Hz
// - crc-8 poly 1Dh, preset FFh, inverted
// - status codes, priority 10,00,11,01
`default_nettype none
module rss_spi_slave
  import rss_pkg::*;
#(
  parameter int T_ACCESS_CYC = rss_pkg::RSS_T_ACCESS_CYC,
  parameter int T_VALID60_CYC = rss_pkg::RSS_T_VALID60_CYC,
  parameter int T_VALID10_CYC = rss_pkg::RSS_T_VALID10_CYC,
  parameter int T_SELFTEST_CYC = rss_pkg::RSS_T_SELFTEST_CYC,
  // arbitrary neutral value
  parameter logic [31:0] SERIAL_NUMBER = 32'h0000_0001
) (
  // system
  input wire logic sys_clk,
  input wire logic rst,
  // serial link
  input wire logic sck,
  input wire logic chip_select_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // sensing core
  input wire logic [15:0] rate_data,
  input wire logic [15:0] temp_data,
  input wire logic [15:0] rate_fault_a_set,
  input wire logic [15:0] rate_fault_b_set,
  input wire logic [15:0] common_fault_set,
  // control out
  output logic rate_valid,
  output logic filter_10hz,
  output logic selftest_active
);
  import rss_pkg::*;

  // -----------------------------------------------------------------------
  // link domain: shifting on rising sck
  // -----------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] shift;
    logic [5:0] cnt;
  } rss_lnk_type;

  typedef struct packed {
    logic [31:0] hold;
    logic len_ok;
  } rss_lhd_type;

  rss_lnk_type lnk_q, lnk_d;
  rss_lhd_type lhd_q, lhd_d;
  logic lnk_rst;

  // frame logic is cleared by chip select itself, sck may stop between frames
  assign lnk_rst = rst | chip_select_n;

  always_comb begin
    lnk_d = lnk_q;
    lhd_d = lhd_q;
    lnk_d.shift = {lnk_q.shift[30:0], mosi};
    if (lnk_q.cnt != 6'h3f) begin
      lnk_d.cnt = lnk_q.cnt + 6'h01;
    end
    // only the 32nd edge leaves a usable word; extra edges spoil it
    lhd_d.len_ok = (lnk_q.cnt == 6'(RSS_FRAME_BITS - 1));
    if (lnk_q.cnt == 6'(RSS_FRAME_BITS - 1)) begin
      lhd_d.hold = {lnk_q.shift[30:0], mosi};
    end
  end

  always_ff @(posedge sck or posedge lnk_rst) begin
    if (lnk_rst) begin
      lnk_q <= '0;
    end else begin
      lnk_q <= lnk_d;
    end
  end

  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      lhd_q <= '0;
    end else begin
      lhd_q <= lhd_d;
    end
  end

  // -----------------------------------------------------------------------
  // system domain state
  // -----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] cs_sy;
    logic [1:0] sck_sy;
    logic cs_d;
    logic sck_d;
    rss_phase_type phase;
    logic [RSS_TMR_W-1:0] tmr;
    logic [1:0] flt;
    logic flt_ok;
    logic [15:0] st_ra;
    logic [15:0] st_rb;
    logic [15:0] st_acc;
    logic [15:0] st_com;
    logic [31:0] resp;
    logic [31:0] tx;
    logic miso;
    logic miso_oe;
    logic rate_valid;
    logic flt10;
    logic frm_clk;
    logic st_act;
  } rss_sys_type;

  rss_sys_type s_q, s_d;

  // -----------------------------------------------------------------------
  // request decode
  // -----------------------------------------------------------------------
  logic [31:0] req;
  logic [5:0] req_op;
  logic [4:0] req_adr;
  logic [15:0] req_dat;
  logic req_crc_ok;
  logic [15:0] summary;
  logic [15:0] dout;
  logic adr_bad;
  logic [1:0] rs;
  logic [RSS_TMR_W-1:0] t_valid;

  // hold is static here: chip select is high and sck idle when it is read
  assign req = lhd_q.hold;
  assign req_op = req[RSS_OP_HI:RSS_OP_LO];
  assign req_adr = req_op[4:0];
  assign req_dat = req[RSS_DAT_HI:RSS_DAT_LO];
  assign req_crc_ok = (rss_crc8(req[31:8]) == req[RSS_CRC_HI:0]);

  always_comb begin
    summary = RSS_SUM_RESET;
    // common ok needs clean common flags and a valid filter write
    summary[RSS_SUM_OKC_BIT] = (s_q.st_com == '0) && s_q.flt_ok;
    summary[RSS_SUM_OKR_BIT] = (s_q.st_ra == '0) && (s_q.st_rb == '0);
    dout = '0;
    adr_bad = 1'b0;
    case (req_adr)
      RSS_ADR_RATE: dout = rate_data;
      RSS_ADR_TEMP: dout = temp_data;
      RSS_ADR_RFLT_A: dout = s_q.st_ra;
      RSS_ADR_RFLT_B: dout = s_q.st_rb;
      RSS_ADR_CFLT: dout = s_q.st_com;
      RSS_ADR_SERL: dout = SERIAL_NUMBER[15:0];
      RSS_ADR_SERH: dout = SERIAL_NUMBER[31:16];
      RSS_ADR_SUM: dout = summary;
      RSS_ADR_RSTCTL: adr_bad = !req[RSS_OP_WR];
      RSS_ADR_AFLT: begin
        // acceleration path is powered down, always a failure
        dout = s_q.st_acc;
        adr_bad = 1'b1;
      end
      default: adr_bad = 1'b1;
    endcase
    if (req[RSS_OP_WR]) begin
      dout = '0;
      if (req_adr != RSS_ADR_SUM && req_adr != RSS_ADR_RSTCTL) begin
        adr_bad = 1'b1;
      end
    end
    // priority test, init, error, normal
    if (s_q.phase == RSS_PH_TEST) begin
      rs = RSS_RS_TEST;
    end else if (s_q.phase != RSS_PH_RUN) begin
      rs = RSS_RS_INIT;
    end else if (adr_bad || !req_crc_ok || summary != (16'h0001 << RSS_SUM_OKC_BIT |
                 16'h0001 << RSS_SUM_OKR_BIT)) begin
      rs = RSS_RS_ERR;
    end else begin
      rs = RSS_RS_NORM;
    end
    // 10 Hz needs the longer settling time
    t_valid = (s_q.flt == RSS_FLT_10HZ) ? RSS_TMR_W'(T_VALID10_CYC) :
              RSS_TMR_W'(T_VALID60_CYC);
  end

  // -----------------------------------------------------------------------
  // system domain next state
  // -----------------------------------------------------------------------
  logic cs_rise;
  logic cs_fall;
  logic sck_fall;
  logic [23:0] resp_hi;

  assign cs_rise = !s_q.cs_d && s_q.cs_sy[1];
  assign cs_fall = s_q.cs_d && !s_q.cs_sy[1];
  assign sck_fall = s_q.sck_d && !s_q.sck_sy[1] && !s_q.cs_sy[1];
  assign resp_hi = {req_op, rs, dout};

  always_comb begin
    s_d = s_q;
    s_d.cs_sy = {s_q.cs_sy[0], chip_select_n};
    s_d.sck_sy = {s_q.sck_sy[0], sck};
    s_d.cs_d = s_q.cs_sy[1];
    s_d.sck_d = s_q.sck_sy[1];
    // sticky fault flags, a new event wins over a read clear
    s_d.st_ra = s_q.st_ra | rate_fault_a_set;
    s_d.st_rb = s_q.st_rb | rate_fault_b_set;
    s_d.st_com = s_q.st_com | common_fault_set;
    s_d.tmr = s_q.tmr + RSS_TMR_W'(1);
    case (s_q.phase)
      RSS_PH_INIT: begin
        // nonvolatile load and self tests run here
        if (s_q.tmr >= RSS_TMR_W'(T_ACCESS_CYC - 1)) begin
          s_d.phase = RSS_PH_OPEN;
        end
      end
      RSS_PH_OPEN: begin
        if (s_q.tmr >= t_valid - RSS_TMR_W'(1)) begin
          s_d.phase = RSS_PH_RUN;
        end
      end
      RSS_PH_TEST: begin
        if (s_q.tmr >= RSS_TMR_W'(T_SELFTEST_CYC - 1)) begin
          s_d.phase = RSS_PH_RUN;
        end
      end
      RSS_PH_RUN: s_d.tmr = s_q.tmr;
      default: s_d.phase = RSS_PH_INIT;
    endcase
    if (s_q.phase == RSS_PH_INIT || s_q.phase == RSS_PH_OPEN) begin
      s_d.st_com = s_d.st_com | RSS_STARTUP_FLAGS;
      s_d.st_ra = s_d.st_ra | RSS_STARTUP_FLAGS;
    end
    // response shifting, mode 0: change after falling sck
    if (cs_fall && s_q.phase != RSS_PH_INIT) begin
      s_d.miso_oe = 1'b1;
      s_d.tx = s_q.resp;
      s_d.miso = s_q.resp[31];
    end else if (sck_fall) begin
      s_d.tx = {s_q.tx[30:0], 1'b0};
      s_d.miso = s_q.tx[30];
    end
    if (cs_rise) begin
      s_d.miso_oe = 1'b0;
    end
    // a frame with no clock at all must not replay the last request
    if (cs_fall) begin
      s_d.frm_clk = 1'b0;
    end else if (!s_q.cs_sy[1] && s_q.sck_sy[1] && !s_q.sck_d) begin
      s_d.frm_clk = 1'b1;
    end
    // the port stays deaf until the access time has passed
    if (cs_rise && lhd_q.len_ok && s_q.frm_clk && s_q.phase != RSS_PH_INIT) begin
      // answer goes out in the next frame
      s_d.resp = {resp_hi, rss_crc8(resp_hi)};
      if (!req[RSS_OP_WR] && req_crc_ok) begin
        // status reads clear, while new events still set
        case (req_adr)
          RSS_ADR_RFLT_A: s_d.st_ra = rate_fault_a_set;
          RSS_ADR_RFLT_B: s_d.st_rb = rate_fault_b_set;
          RSS_ADR_CFLT: s_d.st_com = common_fault_set;
          RSS_ADR_AFLT: s_d.st_acc = RSS_FLAGS_RESET;
          default: s_d.st_acc = s_q.st_acc;
        endcase
      end
      if (req[RSS_OP_WR] && req_crc_ok && req_adr == RSS_ADR_SUM) begin
        case (req_dat[RSS_FLT_HI:RSS_FLT_LO])
          RSS_FLT_10HZ: begin
            s_d.flt = RSS_FLT_10HZ;
            s_d.flt_ok = 1'b1;
          end
          RSS_FLT_60HZ: begin
            s_d.flt = RSS_FLT_60HZ;
            s_d.flt_ok = 1'b1;
          end
          default: begin
            s_d.flt = RSS_FLT_DEF;
            s_d.flt_ok = 1'b0;
          end
        endcase
      end
      if (req[RSS_OP_WR] && req_crc_ok && req_adr == RSS_ADR_RSTCTL) begin
        if (req_dat[RSS_RST_MST_BIT] && s_q.phase == RSS_PH_RUN) begin
          s_d.phase = RSS_PH_TEST;
          s_d.tmr = '0;
        end
        if (req_dat[RSS_RST_FULL_BIT]) begin
          // full restart; the next answer is undefined, shown as zero
          s_d.phase = RSS_PH_INIT;
          s_d.tmr = '0;
          s_d.flt = RSS_FLT_DEF;
          s_d.flt_ok = 1'b0;
          s_d.resp = '0;
          s_d.st_ra = RSS_FLAGS_RESET;
          s_d.st_rb = RSS_FLAGS_RESET;
          s_d.st_acc = RSS_FLAGS_RESET;
          s_d.st_com = RSS_FLAGS_RESET;
        end
      end
    end
    s_d.rate_valid = (s_d.phase == RSS_PH_RUN) || (s_d.phase == RSS_PH_TEST);
    s_d.st_act = (s_d.phase == RSS_PH_TEST);
    // unset filter falls back to the 60 Hz default
    s_d.flt10 = (s_d.flt == RSS_FLT_10HZ);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{cs_sy: 2'h3, sck_sy: 2'h0, cs_d: 1'b1, sck_d: 1'b0,
               phase: RSS_PH_INIT, tmr: '0, flt: RSS_FLT_DEF, flt_ok: 1'b0,
               st_ra: RSS_FLAGS_RESET, st_rb: RSS_FLAGS_RESET,
               st_acc: RSS_FLAGS_RESET, st_com: RSS_FLAGS_RESET,
               resp: '0, tx: '0, miso: 1'b0, miso_oe: 1'b0,
               rate_valid: 1'b0, flt10: 1'b0, frm_clk: 1'b0, st_act: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // -----------------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------------
  assign miso = s_q.miso;
  assign miso_oe = s_q.miso_oe;
  assign rate_valid = s_q.rate_valid;
  assign filter_10hz = s_q.flt10;
  assign selftest_active = s_q.st_act;

endmodule // rss_spi_slave
`default_nettype wire

// >>> rtl/rss_pkg.sv
/*
  rss_pkg: constants, register map, frame layout, start-up timing and the
  frame checksum function for the rate sensor serial slave.
  Assumes a 125 MHz system clock; the serial clock comes from the master.
*/
`default_nettype none
package rss_pkg;
  // ---------------------------------------------------------------------
  // register addresses (five-bit address field of the operation code)
  // ---------------------------------------------------------------------
  localparam logic [4:0] RSS_ADR_RATE = 5'h01;
  localparam logic [4:0] RSS_ADR_TEMP = 5'h07;
  localparam logic [4:0] RSS_ADR_RFLT_A = 5'h09;
  localparam logic [4:0] RSS_ADR_RFLT_B = 5'h0a;
  localparam logic [4:0] RSS_ADR_AFLT = 5'h15;
  localparam logic [4:0] RSS_ADR_RSTCTL = 5'h16;
  localparam logic [4:0] RSS_ADR_SERL = 5'h18;
  localparam logic [4:0] RSS_ADR_SERH = 5'h19;
  localparam logic [4:0] RSS_ADR_CFLT = 5'h1b;
  localparam logic [4:0] RSS_ADR_SUM = 5'h1f;
  // ---------------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------------
  localparam int RSS_FRAME_BITS = 32;
  localparam int RSS_OP_HI = 31;
  localparam int RSS_OP_LO = 26;
  localparam int RSS_OP_WR = 31;
  localparam int RSS_DAT_HI = 23;
  localparam int RSS_DAT_LO = 8;
  localparam int RSS_CRC_HI = 7;
  // ---------------------------------------------------------------------
  // fields inside data words
  // ---------------------------------------------------------------------
  localparam int RSS_FLT_HI = 13;
  localparam int RSS_FLT_LO = 12;
  localparam logic [1:0] RSS_FLT_DEF = 2'h0;
  localparam logic [1:0] RSS_FLT_10HZ = 2'h1;
  localparam logic [1:0] RSS_FLT_60HZ = 2'h2;
  localparam int RSS_RST_FULL_BIT = 2;
  localparam int RSS_RST_MST_BIT = 3;
  localparam int RSS_SUM_OKC_BIT = 6;
  localparam int RSS_SUM_OKR_BIT = 0;
  localparam logic [15:0] RSS_SUM_RESET = 16'h0000;
  localparam logic [15:0] RSS_STARTUP_FLAGS = 16'h0001;
  localparam logic [15:0] RSS_FLAGS_RESET = 16'h0000;
  // ---------------------------------------------------------------------
  // return status codes
  // ---------------------------------------------------------------------
  localparam logic [1:0] RSS_RS_INIT = 2'h0;
  localparam logic [1:0] RSS_RS_NORM = 2'h1;
  localparam logic [1:0] RSS_RS_TEST = 2'h2;
  localparam logic [1:0] RSS_RS_ERR = 2'h3;
  // ---------------------------------------------------------------------
  // checksum
  // ---------------------------------------------------------------------
  localparam logic [7:0] RSS_CRC_POLY = 8'h1d;
  localparam logic [7:0] RSS_CRC_INIT = 8'hff;
  localparam logic [7:0] RSS_CRC_XOR = 8'hff;
  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  localparam int RSS_SYS_CLK_HZ = 125000000;
  localparam int RSS_CYC_PER_MS = RSS_SYS_CLK_HZ / 1000;
  localparam int RSS_T_ACCESS_MS = 20;
  localparam int RSS_T_VALID60_MS = 620;
  localparam int RSS_T_VALID10_MS = 750;
  localparam int RSS_T_SELFTEST_MS = 50;
  localparam int RSS_T_ACCESS_CYC = RSS_T_ACCESS_MS * RSS_CYC_PER_MS;
  localparam int RSS_T_VALID60_CYC = RSS_T_VALID60_MS * RSS_CYC_PER_MS;
  localparam int RSS_T_VALID10_CYC = RSS_T_VALID10_MS * RSS_CYC_PER_MS;
  localparam int RSS_T_SELFTEST_CYC = RSS_T_SELFTEST_MS * RSS_CYC_PER_MS;
  localparam int RSS_TMR_W = 27;

  typedef enum logic [1:0] {
    RSS_PH_INIT = 2'b00,
    RSS_PH_OPEN = 2'b01,
    RSS_PH_RUN = 2'b11,
    RSS_PH_TEST = 2'b10
  } rss_phase_type;

  // msb-first crc over frame bits 31..8
  function automatic logic [7:0] rss_crc8(input logic [23:0] d);
    logic [7:0] c;
    c = RSS_CRC_INIT;
    for (int i = 23; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ RSS_CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c ^ RSS_CRC_XOR;
  endfunction
endpackage
`default_nettype wire

// >>> tb/rss_spi_slave_checker.sv
/*
  rss_spi_slave_checker: port timing checks for the rate sensor serial slave.
  Assumes it is bound to rss_spi_slave; sck is seen only through sys_clk.
*/
`default_nettype none
module rss_spi_slave_checker #(
  parameter int T_ACCESS_CYC = 100,
  parameter int T_VALID60_CYC = 400,
  parameter int T_VALID10_CYC = 600,
  parameter int T_SELFTEST_CYC = 50
) (
  // system
  input wire logic sys_clk,
  input wire logic rst,
  // serial link
  input wire logic sck,
  input wire logic chip_select_n,
  input wire logic miso,
  input wire logic miso_oe,
  // control
  input wire logic rate_valid,
  input wire logic filter_10hz,
  input wire logic selftest_active
);
  timeunit 1ns;
  timeprecision 100ps;
  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  int up_q;
  int st_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      up_q <= 0;
      st_q <= 0;
    end else begin
      // saturates so a long run cannot wrap
      up_q <= (up_q < T_VALID10_CYC + 8) ? up_q + 1 : up_q;
      st_q <= selftest_active ? st_q + 1 : 0;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // -------------------------------------------------------------------
  // properties
  // -------------------------------------------------------------------
  sequence s_idle; chip_select_n [*6]; endsequence
  sequence s_open; $fell(chip_select_n) ##0 rate_valid; endsequence
  property p_oe_off; s_idle |-> !miso_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("miso driven while idle");
  property p_oe_up; s_open |-> ##[2:5] miso_oe; endproperty
  a_oe_up: assert property (p_oe_up) else $error("miso not driven in frame");
  property p_init_quiet; up_q < T_ACCESS_CYC |-> !miso_oe; endproperty
  a_init_quiet: assert property (p_init_quiet) else $error("port open too early");
  property p_early; up_q + 2 < T_VALID60_CYC |-> !rate_valid; endproperty
  a_early: assert property (p_early) else $error("rate valid too early");
  property p_slow; filter_10hz && up_q + 2 < T_VALID10_CYC |-> !rate_valid; endproperty
  a_slow: assert property (p_slow) else $error("slow filter valid too early");
  property p_st_valid; selftest_active |-> rate_valid; endproperty
  a_st_valid: assert property (p_st_valid) else $error("self test before run");
  property p_st_len; selftest_active |-> st_q <= T_SELFTEST_CYC + 2; endproperty
  a_st_len: assert property (p_st_len) else $error("self test too long");
  property p_hold; miso_oe && sck && $past(sck) && $past(sck, 2) |-> $stable(miso); endproperty
  a_hold: assert property (p_hold) else $error("miso moved while sck high");
  property p_flt; !chip_select_n && !$past(chip_select_n) |-> $stable(filter_10hz); endproperty
  a_flt: assert property (p_flt) else $error("filter changed mid frame");
endmodule // rss_spi_slave_checker
bind rss_spi_slave rss_spi_slave_checker #(
  .T_ACCESS_CYC(T_ACCESS_CYC), .T_VALID60_CYC(T_VALID60_CYC),
  .T_VALID10_CYC(T_VALID10_CYC), .T_SELFTEST_CYC(T_SELFTEST_CYC)
) u_chk (
  .sys_clk(sys_clk), .rst(rst), .sck(sck), .chip_select_n(chip_select_n), .miso(miso),
  .miso_oe(miso_oe), .rate_valid(rate_valid), .filter_10hz(filter_10hz),
  .selftest_active(selftest_active)
);
`default_nettype wire

// >>> tb/rss_master_model.sv
/*
  rss_master_model: behavioural serial master, mode 0, 125 ns clock.
  Assumes the bench calls xfer for one frame at a time.
*/
`default_nettype none
module rss_master_model (
  // serial link
  output logic sck,
  output logic chip_select_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last_q = 1'b0;
  logic oe_seen = 1'b0;
  initial begin
    sck = 1'b0;
    chip_select_n = 1'b1;
    mosi = 1'b1;
  end
  // short frames only when the bench asks for one
  task automatic xfer(input logic [31:0] req, input int nb, output logic [31:0] rsp);
    rsp = 32'h0;
    oe_seen = 1'b0;
    #3.3 chip_select_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      mosi = req[31 - i];
      #62.5 sck = 1'b1;
      // undriven line: inverse of last bit, never a lucky match
      last_q = miso_oe ? miso : ~last_q;
      rsp = {rsp[30:0], last_q};
      oe_seen = oe_seen | miso_oe;
      #62.5 sck = 1'b0;
    end
    #62.5 chip_select_n = 1'b1;
    mosi = ~mosi;
    #300;
  endtask
endmodule // rss_master_model
`default_nettype wire

// >>> tb/rss_spi_slave_tb.sv
/*
  rss_spi_slave_tb: self-checking bench for the rate sensor serial slave.
  Assumes rss_master_model as far side and the bound checker.
*/
`default_nettype none
module rss_spi_slave_tb;
  import rss_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  // -------------------------------------------------------------------
  // set-up
  // -------------------------------------------------------------------
  localparam int TA = 1000;
  localparam int T10 = 4000;
  localparam logic [31:0] SER = 32'h0000_5a3c; // arbitrary value
  localparam logic [31:0] M_ALL = 32'hffff_ffff;
  localparam logic [31:0] M_HDR = 32'hff00_0000;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic sck;
  logic chip_select_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic [15:0] rate_data = 16'h0;
  logic [15:0] temp_data = 16'h0;
  logic [15:0] rate_fault_a_set = 16'h0;
  logic [15:0] rate_fault_b_set = 16'h0;
  logic [15:0] common_fault_set = 16'h0;
  logic rate_valid;
  logic filter_10hz;
  logic selftest_active;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int since = 0;
  logic [31:0] r;
  logic [31:0] pend_e = 32'h0;
  logic [31:0] pend_m = 32'h0;
  logic [15:0] v;
  logic [4:0] sreg [3] = '{5'h09, 5'h0a, 5'h1b};
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    since <= rst ? 0 : since + 1;
    if (cyc == 60000) begin
      fail_count++;
      print_verdict();
    end
  end
  rss_spi_slave #(
    .T_ACCESS_CYC(TA), .T_VALID60_CYC(3000), .T_VALID10_CYC(T10), .T_SELFTEST_CYC(2000),
    .SERIAL_NUMBER(SER)
  ) u_dut (
    .sys_clk(sys_clk), .rst(rst), .sck(sck), .chip_select_n(chip_select_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .rate_data(rate_data), .temp_data(temp_data),
    .rate_fault_a_set(rate_fault_a_set), .rate_fault_b_set(rate_fault_b_set),
    .common_fault_set(common_fault_set), .rate_valid(rate_valid), .filter_10hz(filter_10hz),
    .selftest_active(selftest_active)
  );
  rss_master_model u_mst (
    .sck(sck), .chip_select_n(chip_select_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe)
  );
  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  function automatic logic [7:0] crc(input logic [23:0] d);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h1d : 8'h00);
    return ~c;
  endfunction
  function automatic logic [31:0] fr(input logic [5:0] op, input logic [1:0] s,
                                     input logic [15:0] d);
    return {op, s, d, crc({op, s, d})};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    samples_checked++;
    if ((got & m) !== (exp & m)) begin
      fail_count++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // response lags one frame, so each call checks the previous request
  task automatic tx(input logic [31:0] req, input logic [31:0] e, input logic [31:0] m);
    u_mst.xfer(req, 32, r);
    chk(r, pend_e, pend_m);
    pend_e = e;
    pend_m = m;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // -------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------
  initial begin
    void'($urandom(32'h1c65));
    repeat (8) @(posedge sys_clk);
    #1 rst = 1'b0;
    chk(fr(6'h3f, 2'h0, 16'h2000), 32'hfc20_0006, M_ALL);
    tx(fr(6'h01, 2'h0, 16'h0), 32'h0, 32'h0);
    chk({31'h0, u_mst.oe_seen}, 32'h0, M_ALL);
    repeat (TA) @(posedge sys_clk);
    tx(fr(6'h3f, 2'h0, 16'h1000), fr(6'h3f, RSS_RS_INIT, 16'h0), M_HDR);
    chk({31'h0, filter_10hz}, 32'h1, M_ALL);
    tx(fr(6'h09, 2'h0, 16'h0), fr(6'h09, RSS_RS_INIT, 16'h0), M_HDR);
    while (!rate_valid && since < T10 + 100) begin
      @(posedge sys_clk);
      #1;
    end
    chk({31'h0, since + 2 >= T10 && since <= T10 + 4}, 32'h1, M_ALL);
    for (int k = 0; k < 2; k++) begin
      for (int j = 0; j < 3; j++) begin
        v = (k == 0 && j != 1) ? 16'h1 : 16'h0;
        tx(fr({1'b0, sreg[j]}, 2'h0, 16'h0), fr({1'b0, sreg[j]}, RSS_RS_NORM, v),
           k ? M_ALL : 32'hfcff_ff00);
      end
    end
    tx(fr(6'h1f, 2'h0, 16'h0), fr(6'h1f, RSS_RS_NORM, 16'h0041), M_ALL);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      #1 rate_data = (i == 0) ? 16'h8000 : 16'($urandom);
      temp_data = 16'($urandom);
      tx(fr(6'h01, 2'h0, 16'h0), fr(6'h01, RSS_RS_NORM, rate_data), M_ALL);
      tx(fr(6'h07, 2'h0, 16'h0), fr(6'h07, RSS_RS_NORM, temp_data), M_ALL);
    end
    tx(fr(6'h15, 2'h0, 16'h0), fr(6'h15, RSS_RS_ERR, 16'h0), M_ALL);
    tx(fr(6'h19, 2'h0, 16'h0), fr(6'h19, RSS_RS_NORM, SER[31:16]), M_ALL);
    tx(fr(6'h21, 2'h0, 16'h0), 32'h0300_0000, 32'h0300_0000);
    tx(fr(6'h07, 2'h0, 16'h0) ^ 32'h1, 32'h0300_0000, 32'h0300_0000);
    tx(fr(6'h18, 2'h0, 16'h0), fr(6'h18, RSS_RS_NORM, SER[15:0]), M_ALL);
    u_mst.xfer(fr(6'h01, 2'h0, 16'h0), 31, r);
    v = 16'h1 << ($urandom % 16);
    @(posedge sys_clk);
    #1 common_fault_set = v;
    rate_fault_b_set = v;
    @(posedge sys_clk);
    #1 common_fault_set = 16'h0;
    rate_fault_b_set = 16'h0;
    tx(fr(6'h1b, 2'h0, 16'h0), fr(6'h1b, RSS_RS_ERR, v), M_ALL);
    tx(fr(6'h0a, 2'h0, 16'h0), fr(6'h0a, RSS_RS_ERR, v), M_ALL);
    tx(fr(6'h1b, 2'h0, 16'h0), fr(6'h1b, RSS_RS_NORM, 16'h0), M_ALL);
    tx(32'hfc20_0006, 32'hfc00_0000, 32'hfc00_0000);
    chk({31'h0, filter_10hz}, 32'h0, M_ALL);
    tx(fr(6'h3f, 2'h0, 16'h3000), 32'h0, 32'h0);
    tx(fr(6'h1f, 2'h0, 16'h0), fr(6'h1f, RSS_RS_ERR, 16'h0001), M_ALL);
    tx(32'hd800_08ad, 32'h0, 32'h0);
    chk({31'h0, selftest_active}, 32'h1, M_ALL);
    tx(fr(6'h01, 2'h0, 16'h0), fr(6'h01, RSS_RS_TEST, 16'h0), M_HDR);
    tx(32'hd800_0431, 32'h0, 32'h0);
    chk({31'h0, rate_valid}, 32'h0, M_ALL);
    print_verdict();
  end
endmodule // rss_spi_slave_tb
`default_nettype wire
